//--- scr_top.sv
// Serial-loaded configuration registers and standby control of the synthesizer
`timescale 1ns/10ps

module scr_top #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // Serial port from host
  input  wire logic        serial_clk_in,
  input  wire logic        serial_data_in,
  input  wire logic        serial_load_strobe_in,
  // Detector pulses from counters
  input  wire logic        ref_divided_freq_in,
  input  wire logic        vco_divided_freq_in,
  input  wire logic        ref_terminal_in,
  input  wire logic        raw_phase_r_n_in,
  input  wire logic        raw_phase_v_n_in,
  input  wire logic        raw_pump_up_in,
  input  wire logic        raw_pump_dn_in,
  // Detector outputs
  output logic             pump_source_out,
  output logic             pump_sink_out,
  output logic             single_ended_detector_output_oe_out,
  output logic             phase_r_n_out,
  output logic             phase_v_n_out,
  output logic             lock_indicator_out,
  // Control to analog and counters
  output logic [1:0]       pump_current_sel_out,
  output logic [1:0]       pump_step_out,
  output logic             bias_enable_out,
  output logic             counters_run_out,
  output logic             r_jam_load_out,
  output logic             detector_init_out,
  output logic             detectors_enabled_out,
  output logic             ref_input_inhibit_out,
  output logic [2:0]       ref_osc_mode_out,
  output logic [12:0]      r_divide_out,
  output logic [23:0]      swallow_and_main_divide_out,
  // General purpose outputs
  output logic             port_pin_out,
  output logic             open_drain_oe_out,
  output logic             open_drain_out
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Serial port, counter pulses and phase AND pass two flops, and only the second stage is used; raw pump, raw phase and ref_terminal_in paths bypass them
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] async_in;
  assign async_in = {serial_clk_in, serial_data_in, serial_load_strobe_in,
                     ref_divided_freq_in, vco_divided_freq_in, ref_terminal_in,
                     raw_phase_r_n_in & raw_phase_v_n_in, 1'b0};
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // Idle pin levels so no false edge or strobe follows reset
      sync1 <= 8'h02;
      sync2 <= 8'h02;
    end else begin
      sync1 <= async_in;
      sync2 <= sync1;
    end
  end
  logic sclk_s, sdat_s, stb_s, fv_s;
  assign sclk_s = sync2[7];
  assign sdat_s = sync2[6];
  assign stb_s  = sync2[5];
  assign fv_s   = sync2[3];

  // ----------------------------------------
  // Serial shift and register state
  // ----------------------------------------
  logic [23:0] shreg, next_shreg;
  logic [5:0]  nbits, next_nbits;
  logic        sclk_d, stb_d, fv_d;
  logic [7:0]  cfg, next_cfg;
  logic [23:0] areg, next_areg;
  logic [2:0]  rosc, next_rosc;
  logic [12:0] rbuf1, next_rbuf1;
  logic [12:0] rbuf2, next_rbuf2;
  logic [12:0] ract, next_ract;
  logic        sclk_rise, stb_fall, fv_rise;

  assign sclk_rise = sclk_s & ~sclk_d;
  assign stb_fall  = ~stb_s & stb_d;
  assign fv_rise   = fv_s & ~fv_d;

  always_comb begin
    next_shreg = shreg;
    next_nbits = nbits;
    next_cfg   = cfg;
    next_areg  = areg;
    next_rosc  = rosc;
    next_rbuf1 = rbuf1;
    next_rbuf2 = rbuf2;
    next_ract  = ract;
    if (stb_s && sclk_rise) begin
      next_shreg = {shreg[22:0], sdat_s};
      if (nbits != 6'h3f) begin
        next_nbits = nbits + 6'h01;
      end
    end
    if (stb_fall) begin
      next_nbits = 6'h00;
      if (nbits == 6'(scr_pkg::CFG_BITS)) begin
        next_cfg = shreg[7:0];
      end else if (nbits == 6'(scr_pkg::REF_BITS)) begin
        next_rosc  = shreg[scr_pkg::R_OSC_LSB +: 3];
        next_rbuf1 = shreg[scr_pkg::R_DIV_W-1:0];
      end else if (nbits == 6'(scr_pkg::DIV_BITS)) begin
        next_areg  = shreg;
        next_rbuf2 = rbuf1;
      end else if (nbits == 6'h00) begin
        next_rbuf2 = rbuf1;
      end
    end
    if (ref_terminal_in) begin
      next_ract = rbuf2;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shreg  <= 24'h000000;
      nbits  <= 6'h00;
      sclk_d <= 1'b0;
      stb_d  <= 1'b0;
      fv_d   <= 1'b0;
      cfg    <= scr_pkg::CFG_RESET;
      areg   <= scr_pkg::A_RESET;
      rosc   <= scr_pkg::R_OSC_RESET;
      rbuf1  <= scr_pkg::R_DIV_RESET;
      rbuf2  <= scr_pkg::R_DIV_RESET;
      ract   <= scr_pkg::R_DIV_RESET;
    end else begin
      shreg  <= next_shreg;
      nbits  <= next_nbits;
      sclk_d <= sclk_s;
      stb_d  <= stb_s;
      fv_d   <= fv_s;
      cfg    <= next_cfg;
      areg   <= next_areg;
      rosc   <= next_rosc;
      rbuf1  <= next_rbuf1;
      rbuf2  <= next_rbuf2;
      ract   <= next_ract;
    end
  end

  // ----------------------------------------
  // Standby recovery sequence
  // ----------------------------------------
  // Detectors stay blocked until the first divided VCO pulse aligns them
  scr_pkg::scr_state_t st, next_st;
  logic low_power_hold;
  assign low_power_hold = cfg[scr_pkg::CFG_LOW_POWER_HOLD];

  always_comb begin
    next_st = st;
    case (st)
      scr_pkg::SCR_RUN: begin
        if (low_power_hold) begin
          next_st = scr_pkg::SCR_HOLD;
        end
      end
      scr_pkg::SCR_HOLD: begin
        if (!low_power_hold) begin
          next_st = scr_pkg::SCR_WAIT;
        end
      end
      scr_pkg::SCR_WAIT: begin
        if (low_power_hold) begin
          next_st = scr_pkg::SCR_HOLD;
        end else if (fv_rise) begin
          next_st = scr_pkg::SCR_RUN;
        end
      end
      default: next_st = scr_pkg::SCR_RUN;
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= scr_pkg::SCR_RUN;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Output decode
  // ----------------------------------------
  logic detector_polarity, sel_single, lock_pin_enable, port_mode, det_on, in_hold;
  assign detector_polarity        = cfg[scr_pkg::CFG_POL];
  assign sel_single = cfg[scr_pkg::CFG_SEL];
  assign lock_pin_enable        = cfg[scr_pkg::CFG_LDE];
  assign port_mode  = areg[scr_pkg::A_MODE_LO +: 2] == scr_pkg::A_MODE_PORT;
  assign in_hold    = (st == scr_pkg::SCR_HOLD);
  assign det_on     = (st == scr_pkg::SCR_RUN) && !low_power_hold;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pump_source_out                     <= 1'b0;
      pump_sink_out                       <= 1'b0;
      single_ended_detector_output_oe_out <= 1'b0;
      phase_r_n_out                       <= 1'b1;
      phase_v_n_out                       <= 1'b1;
      lock_indicator_out                  <= 1'b0;
      pump_current_sel_out                <= 2'h0;
      pump_step_out                       <= scr_pkg::STEP_10;
      bias_enable_out                     <= 1'b1;
      counters_run_out                    <= 1'b1;
      r_jam_load_out                      <= 1'b0;
      detector_init_out                   <= 1'b0;
      detectors_enabled_out               <= 1'b1;
      ref_input_inhibit_out               <= 1'b0;
      ref_osc_mode_out                    <= scr_pkg::R_OSC_RESET;
      r_divide_out                        <= scr_pkg::R_DIV_RESET;
      swallow_and_main_divide_out         <= scr_pkg::A_RESET;
      port_pin_out                        <= 1'b0;
      open_drain_oe_out                   <= 1'b1;
      open_drain_out                      <= 1'b0;
    end else begin
      // Polarity swaps pump direction and detector roles
      pump_source_out <= det_on && (detector_polarity ? raw_pump_dn_in : raw_pump_up_in);
      pump_sink_out   <= det_on && (detector_polarity ? raw_pump_up_in : raw_pump_dn_in);
      single_ended_detector_output_oe_out <= sel_single && !low_power_hold && !in_hold;
      phase_r_n_out <= (sel_single || low_power_hold || !det_on) ? 1'b1
                       : (detector_polarity ? raw_phase_v_n_in : raw_phase_r_n_in);
      phase_v_n_out <= (sel_single || low_power_hold || !det_on) ? 1'b1
                       : (detector_polarity ? raw_phase_r_n_in : raw_phase_v_n_in);
      // Lock gating uses synced AND; in recovery lock stays quiet-high
      if (!lock_pin_enable) begin
        lock_indicator_out <= 1'b0;
      end else if (low_power_hold || !det_on) begin
        lock_indicator_out <= 1'b1;
      end else begin
        lock_indicator_out <= sync2[1];
      end
      pump_current_sel_out <= {cfg[scr_pkg::CFG_IHI], cfg[scr_pkg::CFG_ILO]};
      pump_step_out <= (!port_mode && cfg[scr_pkg::CFG_PORT]) ? scr_pkg::STEP_25
                       : scr_pkg::STEP_10;
      bias_enable_out       <= !in_hold && !low_power_hold;
      counters_run_out      <= !in_hold && !low_power_hold;
      r_jam_load_out        <= (st == scr_pkg::SCR_WAIT) && !low_power_hold && fv_rise;
      detector_init_out     <= (st == scr_pkg::SCR_WAIT) && !low_power_hold && fv_rise;
      detectors_enabled_out <= det_on;
      ref_input_inhibit_out <= low_power_hold && (rosc == scr_pkg::R_OSC_STATIC_LOW);
      ref_osc_mode_out      <= rosc;
      r_divide_out          <= ract;
      swallow_and_main_divide_out <= areg;
      port_pin_out      <= port_mode && cfg[scr_pkg::CFG_PORT];
      open_drain_oe_out <= !cfg[scr_pkg::CFG_OUTB];
      open_drain_out    <= 1'b0;
    end
  end

endmodule

//--- scr_pkg.sv
// Shared constants for the synthesizer configuration register bank
package scr_pkg;

  // ----------------------------------------
  // Serial frame lengths
  // ----------------------------------------
  localparam int CFG_BITS = 8;
  localparam int REF_BITS = 16;
  localparam int DIV_BITS = 24;

  // ----------------------------------------
  // Config byte fields
  // ----------------------------------------
  localparam int CFG_POL  = 7;
  localparam int CFG_SEL  = 6;
  localparam int CFG_LDE  = 5;
  localparam int CFG_LOW_POWER_HOLD = 4;
  localparam int CFG_IHI  = 3;
  localparam int CFG_ILO  = 2;
  localparam int CFG_PORT = 1;
  localparam int CFG_OUTB = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ----------------------------------------
  // A register fields
  // ----------------------------------------
  localparam int A_MODE_LO = 22;
  localparam logic [1:0] A_MODE_PORT = 2'h3;
  localparam int A_SWALLOW_W = 6;
  localparam int A_MAIN_LSB = 6;
  localparam int A_MAIN_W = 10;
  localparam logic [23:0] A_RESET = 24'h000000;

  // ----------------------------------------
  // R register fields
  // ----------------------------------------
  localparam int R_DIV_W = 13;
  localparam int R_OSC_LSB = 13;
  localparam logic [2:0] R_OSC_RESET = 3'h3;
  localparam logic [2:0] R_OSC_STATIC_LOW = 3'h0;
  localparam logic [12:0] R_DIV_RESET = 13'h0001;

  // ----------------------------------------
  // Current step codes
  // ----------------------------------------
  localparam logic [1:0] STEP_10 = 2'h0;
  localparam logic [1:0] STEP_25 = 2'h1;

  // Recovery sequence
  typedef enum logic [2:0] {
    SCR_RUN  = 3'b001,
    SCR_HOLD = 3'b010,
    SCR_WAIT = 3'b100
  } scr_state_t;

endpackage

//--- scr_host.sv
// Host model that drives the serial port
`timescale 1ns/10ps
module scr_host (
  // Serial port to device
  output logic sclk_out,
  output logic sdata_out,
  output logic strobe_out
);
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    strobe_out = 1'b0;
  end
  // Clock idles low outside frames; data inverts once sampled
  task automatic frame(input logic [23:0] v, input int n);
    strobe_out = 1'b1;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      #8 sdata_out = v[i];
      #8 sclk_out = 1'b1;
      #16 sclk_out = 1'b0;
      sdata_out = ~v[i];
    end
    #40 strobe_out = 1'b0;
    #40;
  endtask
endmodule

//--- scr_checker.sv
// Assertion checker for the synthesizer register bank
`timescale 1ns/10ps
module scr_checker (
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        rstn_in,
  // Watched ports
  input wire logic        ref_terminal_in,
  input wire logic        phase_r_n_out,
  input wire logic        phase_v_n_out,
  input wire logic        single_ended_detector_output_oe_out,
  input wire logic        counters_run_out,
  input wire logic        bias_enable_out,
  input wire logic        r_jam_load_out,
  input wire logic        detector_init_out,
  input wire logic        detectors_enabled_out,
  input wire logic        ref_input_inhibit_out,
  input wire logic [2:0]  ref_osc_mode_out,
  input wire logic [12:0] r_divide_out,
  input wire logic        open_drain_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  a_standby_rest: assert property (!counters_run_out |-> phase_r_n_out && phase_v_n_out
    && !single_ended_detector_output_oe_out) else $error("standby outputs active");
  a_bias_run: assert property (bias_enable_out == counters_run_out)
    else $error("bias and counters differ");
  a_single_rest: assert property (single_ended_detector_output_oe_out |->
    phase_r_n_out && phase_v_n_out) else $error("double outputs not at rest");
  a_jam_once: assert property (r_jam_load_out |=> !r_jam_load_out)
    else $error("jam pulse too long");
  a_jam_unblock: assert property (r_jam_load_out |-> detector_init_out
    ##[0:1] detectors_enabled_out) else $error("detectors not unblocked");
  a_recover_blocked: assert property ($rose(counters_run_out) |-> !detectors_enabled_out)
    else $error("detectors open too early");
  a_inhibit_cause: assert property (ref_input_inhibit_out |-> !counters_run_out
    && ref_osc_mode_out == 3'h0) else $error("inhibit without cause");
  a_ratio_hold: assert property (!$stable(r_divide_out) |->
    $past(ref_terminal_in) || $past(ref_terminal_in, 2)) else $error("ratio moved early");
  a_od_low: assert property (open_drain_out == 1'b0)
    else $error("open drain driven high");
  c_jam: cover property (r_jam_load_out);
  c_inhibit: cover property (ref_input_inhibit_out);
  c_ratio: cover property (!$stable(r_divide_out));
endmodule
bind scr_top scr_checker u_chk (.clock_in, .rstn_in, .ref_terminal_in, .phase_r_n_out,
  .phase_v_n_out, .single_ended_detector_output_oe_out, .counters_run_out,
  .bias_enable_out, .r_jam_load_out, .detector_init_out, .detectors_enabled_out,
  .ref_input_inhibit_out, .ref_osc_mode_out, .r_divide_out, .open_drain_out);

//--- testbench.sv
// Self-checking bench for the synthesizer register bank
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic clock_in = 1'b0, rstn_in = 1'b0, ref_terminal_in = 1'b0;
  logic serial_clk_in, serial_data_in, serial_load_strobe_in;
  logic ref_divided_freq_in = 1'b0, vco_divided_freq_in = 1'b0;
  logic raw_phase_r_n_in = 1'b1, raw_phase_v_n_in = 1'b1;
  logic raw_pump_up_in = 1'b0, raw_pump_dn_in = 1'b0;
  logic pump_source_out, pump_sink_out, single_ended_detector_output_oe_out;
  logic phase_r_n_out, phase_v_n_out, lock_indicator_out, bias_enable_out;
  logic counters_run_out, r_jam_load_out, detector_init_out, detectors_enabled_out;
  logic ref_input_inhibit_out, port_pin_out, open_drain_oe_out, open_drain_out;
  logic [1:0]  pump_current_sel_out, pump_step_out;
  logic [2:0]  ref_osc_mode_out;
  logic [12:0] r_divide_out;
  logic [23:0] swallow_and_main_divide_out;
  integer      seed = 32'hb09032c1;
  int          fail_count = 0, num_checks = 0;
  int          cfg = 0, areg = 0, rb1 = 1, rb2 = 1, act = 1, ocode = 3, r;
  always #2 clock_in = ~clock_in;
  // Detector pulses run free so recovery always ends
  always @(negedge clock_in) begin
    raw_pump_up_in <= $random(seed);
    raw_pump_dn_in <= $random(seed);
    vco_divided_freq_in <= $random(seed);
    ref_divided_freq_in <= $random(seed);
  end
  scr_host host (.sclk_out(serial_clk_in), .sdata_out(serial_data_in),
    .strobe_out(serial_load_strobe_in));
  scr_top dut (.clock_in, .rstn_in, .serial_clk_in, .serial_data_in, .serial_load_strobe_in,
    .ref_divided_freq_in, .vco_divided_freq_in, .ref_terminal_in, .raw_phase_r_n_in,
    .raw_phase_v_n_in, .raw_pump_up_in, .raw_pump_dn_in, .pump_source_out, .pump_sink_out,
    .single_ended_detector_output_oe_out, .phase_r_n_out, .phase_v_n_out,
    .lock_indicator_out, .pump_current_sel_out, .pump_step_out, .bias_enable_out,
    .counters_run_out, .r_jam_load_out, .detector_init_out, .detectors_enabled_out,
    .ref_input_inhibit_out, .ref_osc_mode_out, .r_divide_out, .swallow_and_main_divide_out,
    .port_pin_out, .open_drain_oe_out, .open_drain_out);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_all();
    logic sb, pm, rr, rv;
    repeat (30) @(negedge clock_in);
    sb = cfg[4];
    pm = areg[23:22] == scr_pkg::A_MODE_PORT;
    rr = raw_phase_r_n_in;
    rv = raw_phase_v_n_in;
    chk(pump_current_sel_out, cfg[3:2]);
    chk(pump_step_out, (pm || !cfg[1]) ? scr_pkg::STEP_10 : scr_pkg::STEP_25);
    chk(port_pin_out, pm & cfg[1]);
    chk(open_drain_oe_out, !cfg[0]);
    chk(counters_run_out, !sb);
    chk(bias_enable_out, !sb);
    chk(detectors_enabled_out, !sb);
    chk(pump_source_out, !sb & (cfg[7] ? raw_pump_dn_in : raw_pump_up_in));
    chk(pump_sink_out, !sb & (cfg[7] ? raw_pump_up_in : raw_pump_dn_in));
    chk(open_drain_out, 1'b0);
    chk(single_ended_detector_output_oe_out, cfg[6] & !sb);
    chk(phase_r_n_out, sb | cfg[6] | (cfg[7] ? rv : rr));
    chk(phase_v_n_out, sb | cfg[6] | (cfg[7] ? rr : rv));
    chk(lock_indicator_out, cfg[5] & (sb | (rr & rv)));
    chk(ref_input_inhibit_out, sb && ocode == 0);
    chk(swallow_and_main_divide_out, areg);
    chk(ref_osc_mode_out, ocode);
    chk(r_divide_out, act);
  endtask
  task automatic wr(input logic [23:0] v, input int n);
    host.frame(v, n);
    repeat (8) @(negedge clock_in);
  endtask
  task automatic tick();
    ref_terminal_in = 1'b1;
    @(negedge clock_in);
    ref_terminal_in = 1'b0;
    act = rb2;
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clock_in);
    rstn_in = 1'b1;
    check_all();
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed) & 16'hffff;
      if (i == 3) r = r & 16'h1fff;
      wr(r, 16);
      ocode = r >> 13;
      rb1 = r & 16'h1fff;
      check_all();
      if (i[0]) begin
        wr(0, 0);
        rb2 = rb1;
        check_all();
        tick();
      end
      areg = ($random(seed) & 24'hc0003f) | ((($random(seed) & 10'h3ff) | 10'h040) << 6);
      wr(areg, 24);
      rb2 = rb1;
      cfg = $random(seed) & 8'hff;
      if (i == 3) cfg = cfg | 8'h10;
      wr(cfg, 8);
      wr($random(seed), 12);
      {raw_phase_r_n_in, raw_phase_v_n_in} = 2'(i % 3 + 1);
      check_all();
      tick();
      check_all();
      $display("pass %0d done", i);
    end
    tally_and_finish();
  end
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule
